// >>> logic/pms_pkg.sv
// Purpose: Shared constants and types of the power mode sequencer
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes:   Byte offsets on a 32-bit register bus
package pms_pkg;
   localparam int          AXI_ADDR_W       = 8;
   localparam int          AXI_DATA_W       = 32;
   localparam logic [7:0]  PLL_CONTROL_REG_OFS      = 8'h00;
   localparam logic [7:0]  MODE_CMD_OFS     = 8'h04;
   localparam logic [7:0]  WAKE_EN_OFS      = 8'h08;
   localparam logic [7:0]  REG_CTL_OFS      = 8'h0C;
   localparam logic [7:0]  STATUS_OFS       = 8'h10;
   // Control register fields
   localparam int          PLL_BYPASS_BIT   = 0;
   localparam int          PLL_OFF_BIT      = 1;
   localparam int          LEVEL_LSB        = 0;
   localparam int          RTC_EN_BIT       = 8;
   localparam int          USB_EN_BIT       = 9;
   localparam int          ETH_EN_BIT       = 10;
   localparam int          PHY_EN_BIT       = 11;
   localparam int          SDRAM_HOLD_BIT   = 12;
   localparam int          REG_CTL_W        = 13;
   localparam logic [1:0]  LEVEL_OFF        = 2'h0;
   // Reset values
   localparam logic [1:0]  PLL_CONTROL_REG_RST      = 2'h0;
   localparam logic [12:0] REG_CTL_RST      = 13'h0F03;
   // Mode request codes
   localparam logic [2:0]  CMD_FULL_ON      = 3'h1;
   localparam logic [2:0]  CMD_ACTIVE       = 3'h2;
   localparam logic [2:0]  CMD_SLEEP        = 3'h3;
   localparam logic [2:0]  CMD_DEEP_SLEEP   = 3'h4;
   // Status fields
   localparam int          STAT_CORE_BIT    = 4;
   localparam int          STAT_SYS_BIT     = 5;
   localparam int          STAT_PLL_BIT     = 6;
   localparam int          STAT_BYP_BIT     = 7;
   localparam int          STAT_DMA_BIT     = 8;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;
   // Wake reset sequence length
   localparam int          CLK_PERIOD_NS    = 8;
   localparam int          RST_SEQ_NS       = 1000;
   localparam int          RST_SEQ_CYC      = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SEQ_CNT_W        = 8;

   typedef enum logic [2:0] {
      PM_FULL_ON,
      PM_ACTIVE,
      PM_SLEEP,
      PM_DEEP_SLEEP,
      PM_HIBERNATE,
      PM_RESET_SEQ
   } pms_state_type;
endpackage : pms_pkg

// >>> logic/pms_sequencer.sv
// Purpose: Operating-mode sequencer with AXI4-Lite registers
// Assumes: One 125 MHz clock, synchronous active-high reset
// Notes:   Gating outputs are registered for glitch-free changes
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
module pms_sequencer
   import pms_pkg::*;
#(
   parameter int WAKE_W = 8
) (
   // Clock and reset
   input  wire logic                             CLOCK_IN,
   input  wire logic                             SYS_RST_IN,
   // AXI4-Lite write
   input  wire logic [pms_pkg::AXI_ADDR_W-1:0]   S_AXI_AWADDR_IN,
   input  wire logic                             S_AXI_AWVALID_IN,
   output logic                                  S_AXI_AWREADY_OUT,
   input  wire logic [pms_pkg::AXI_DATA_W-1:0]   S_AXI_WDATA_IN,
   input  wire logic [3:0]                       S_AXI_WSTRB_IN,
   input  wire logic                             S_AXI_WVALID_IN,
   output logic                                  S_AXI_WREADY_OUT,
   output logic [1:0]                            S_AXI_BRESP_OUT,
   output logic                                  S_AXI_BVALID_OUT,
   input  wire logic                             S_AXI_BREADY_IN,
   // AXI4-Lite read
   input  wire logic [pms_pkg::AXI_ADDR_W-1:0]   S_AXI_ARADDR_IN,
   input  wire logic                             S_AXI_ARVALID_IN,
   output logic                                  S_AXI_ARREADY_OUT,
   output logic [pms_pkg::AXI_DATA_W-1:0]        S_AXI_RDATA_OUT,
   output logic [1:0]                            S_AXI_RRESP_OUT,
   output logic                                  S_AXI_RVALID_OUT,
   input  wire logic                             S_AXI_RREADY_IN,
   // Wake sources
   input  wire logic [WAKE_W-1:0]                WAKE_SRC_IN,
   input  wire logic                             RTC_EVENT_IN,
   input  wire logic                             USB_WAKE_IN,
   input  wire logic                             ETH_WAKE_IN,
   input  wire logic                             PHY_WAKE_PIN_N_IN,
   // Clock, power and pin control
   output logic                                  CORE_CLK_EN_OUT,
   output logic                                  SYS_CLK_EN_OUT,
   output logic                                  PLL_EN_OUT,
   output logic                                  PLL_BYPASS_OUT,
   output logic                                  DMA_L1_EN_OUT,
   output logic                                  ASYNC_BLOCK_OUT,
   output logic                                  CORE_POWER_OUT,
   output logic                                  REG_WAKE_A_OUT,
   output logic                                  REG_WAKE_B_OUT,
   output logic                                  PIN_DRIVE_EN_N_OUT,
   output logic                                  SDRAM_SELF_REFRESH_OUT,
   output logic                                  WAKE_RESET_OUT
);
   if (WAKE_W < 1 || WAKE_W > 16) begin : g_bad_width
      $error("WAKE_W must lie in 1 to 16");
   end

   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : merge_strb

   function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
      return (a == PLL_CONTROL_REG_OFS) || (a == MODE_CMD_OFS) || (a == WAKE_EN_OFS)
          || (a == REG_CTL_OFS) || (a == STATUS_OFS);
   endfunction : is_mapped

   // Synchronised pins
   logic [WAKE_W+3:0] sync_q;
   logic [WAKE_W-1:0] wake_s;
   logic              rtc_s;
   logic              usb_s;
   logic              eth_s;
   logic              phy_n_s;

   pms_sync2 #(.W(WAKE_W + 4)) u_sync (
      .clk_in (CLOCK_IN),
      .rst_in (SYS_RST_IN),
      .d_in   ({WAKE_SRC_IN, RTC_EVENT_IN, USB_WAKE_IN, ETH_WAKE_IN, ~PHY_WAKE_PIN_N_IN}),
      .q_out  (sync_q)
   );
   assign wake_s  = sync_q[WAKE_W+3:4];
   assign rtc_s   = sync_q[3];
   assign usb_s   = sync_q[2];
   assign eth_s   = sync_q[1];
   assign phy_n_s = sync_q[0];

   // Bus state
   logic                  aw_full, next_aw_full;
   logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic                  w_full, next_w_full;
   logic [31:0]           w_data, next_w_data;
   logic [3:0]            w_strb, next_w_strb;
   logic                  bvalid, next_bvalid;
   logic [1:0]            bresp, next_bresp;
   logic                  rvalid, next_rvalid;
   logic [31:0]           rdata, next_rdata;
   logic [1:0]            rresp, next_rresp;
   logic                  wr_fire;
   logic [31:0]           status_word;

   // Register and sequencing state
   logic [1:0]            pll_control_reg, next_pll_control_reg;
   logic [WAKE_W-1:0]     wake_en, next_wake_en;
   logic [REG_CTL_W-1:0]  reg_ctl, next_reg_ctl;
   pms_state_type         state, next_state;
   logic [SEQ_CNT_W-1:0]  seq_cnt, next_seq_cnt;
   logic                  mode_req;
   logic [2:0]            mode_code;
   logic                  hib_req;
   logic                  sleep_wake;
   logic                  hib_wake;
   logic [31:0]           wr_merged;

   assign S_AXI_AWREADY_OUT = !aw_full && !bvalid;
   assign S_AXI_WREADY_OUT  = !w_full && !bvalid;
   assign S_AXI_ARREADY_OUT = !rvalid;
   assign S_AXI_BVALID_OUT  = bvalid;
   assign S_AXI_BRESP_OUT   = bresp;
   assign S_AXI_RVALID_OUT  = rvalid;
   assign S_AXI_RDATA_OUT   = rdata;
   assign S_AXI_RRESP_OUT   = rresp;
   assign wr_fire           = aw_full && w_full && !bvalid;

   always_comb begin
      status_word                = '0;
      status_word[2:0]           = state;
      status_word[STAT_CORE_BIT] = CORE_CLK_EN_OUT;
      status_word[STAT_SYS_BIT]  = SYS_CLK_EN_OUT;
      status_word[STAT_PLL_BIT]  = PLL_EN_OUT;
      status_word[STAT_BYP_BIT]  = PLL_BYPASS_OUT;
      status_word[STAT_DMA_BIT]  = DMA_L1_EN_OUT;
   end

   // Bus channels
   always_comb begin
      next_aw_full = aw_full;
      next_aw_addr = aw_addr;
      next_w_full  = w_full;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
         next_aw_full = 1'b1;
         next_aw_addr = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
         next_w_full = 1'b1;
         next_w_data = S_AXI_WDATA_IN;
         next_w_strb = S_AXI_WSTRB_IN;
      end
      if (wr_fire) begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && S_AXI_BREADY_IN) begin
         next_bvalid = 1'b0;
      end
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         if (S_AXI_ARADDR_IN == PLL_CONTROL_REG_OFS) begin
            next_rdata = {30'h0, pll_control_reg};
         end else if (S_AXI_ARADDR_IN == MODE_CMD_OFS) begin
            next_rdata = '0;
         end else if (S_AXI_ARADDR_IN == WAKE_EN_OFS) begin
            next_rdata = 32'(wake_en);
         end else if (S_AXI_ARADDR_IN == REG_CTL_OFS) begin
            next_rdata = 32'(reg_ctl);
         end else if (S_AXI_ARADDR_IN == STATUS_OFS) begin
            next_rdata = status_word;
         end else begin
            next_rdata = '0;
            next_rresp = RESP_SLVERR;
         end
      end else if (rvalid && S_AXI_RREADY_IN) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         w_full  <= 1'b0;
         w_data  <= '0;
         w_strb  <= '0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         aw_addr <= next_aw_addr;
         w_full  <= next_w_full;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // Registers and write side effects
   always_comb begin
      next_pll_control_reg = pll_control_reg;
      next_wake_en = wake_en;
      next_reg_ctl = reg_ctl;
      mode_req     = 1'b0;
      mode_code    = 3'h0;
      hib_req      = 1'b0;
      wr_merged    = '0;
      if (wr_fire) begin
         if (aw_addr == PLL_CONTROL_REG_OFS) begin
            wr_merged    = merge_strb({30'h0, pll_control_reg}, w_data, w_strb);
            next_pll_control_reg = wr_merged[1:0];
         end else if (aw_addr == MODE_CMD_OFS) begin
            mode_req  = w_strb[0];
            mode_code = w_data[2:0];
         end else if (aw_addr == WAKE_EN_OFS) begin
            wr_merged    = merge_strb(32'(wake_en), w_data, w_strb);
            next_wake_en = wr_merged[WAKE_W-1:0];
         end else if (aw_addr == REG_CTL_OFS) begin
            wr_merged    = merge_strb(32'(reg_ctl), w_data, w_strb);
            next_reg_ctl = wr_merged[REG_CTL_W-1:0];
            hib_req      = w_strb[0] && (wr_merged[LEVEL_LSB +: 2] == LEVEL_OFF);
         end
      end
      if (state == PM_HIBERNATE && hib_wake) begin
         next_pll_control_reg = PLL_CONTROL_REG_RST;
         next_wake_en = '0;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         pll_control_reg <= PLL_CONTROL_REG_RST;
         wake_en <= '0;
         reg_ctl <= REG_CTL_RST;
      end else begin
         pll_control_reg <= next_pll_control_reg;
         wake_en <= next_wake_en;
         reg_ctl <= next_reg_ctl;
      end
   end

   // Operating state
   assign sleep_wake = |(wake_s & wake_en);
   assign hib_wake   = (rtc_s && reg_ctl[RTC_EN_BIT]) || (usb_s && reg_ctl[USB_EN_BIT])
                    || (eth_s && reg_ctl[ETH_EN_BIT])
                    || (phy_n_s && reg_ctl[PHY_EN_BIT]);

   always_comb begin
      next_state   = state;
      next_seq_cnt = seq_cnt;
      case (state)
         PM_FULL_ON, PM_ACTIVE: begin
            if (hib_req) begin
               next_state = PM_HIBERNATE;
            end else if (mode_req) begin
               if (mode_code == CMD_FULL_ON) begin
                  next_state = PM_FULL_ON;
               end else if (mode_code == CMD_ACTIVE) begin
                  next_state = PM_ACTIVE;
               end else if (mode_code == CMD_SLEEP) begin
                  next_state = PM_SLEEP;
               end else if (mode_code == CMD_DEEP_SLEEP) begin
                  next_state = PM_DEEP_SLEEP;
               end
            end
         end
         PM_SLEEP: begin
            if (sleep_wake) begin
               next_state = pll_control_reg[PLL_BYPASS_BIT] ? PM_ACTIVE : PM_FULL_ON;
            end
         end
         PM_DEEP_SLEEP: begin
            if (rtc_s) begin
               next_state = PM_ACTIVE;
            end
         end
         PM_HIBERNATE: begin
            if (hib_wake) begin
               next_state   = PM_RESET_SEQ;
               next_seq_cnt = SEQ_CNT_W'(RST_SEQ_CYC - 1);
            end
         end
         PM_RESET_SEQ: begin
            if (seq_cnt == '0) begin
               next_state = PM_FULL_ON;
            end else begin
               next_seq_cnt = seq_cnt - 1'b1;
            end
         end
         default: next_state = PM_FULL_ON;
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         state   <= PM_FULL_ON;
         seq_cnt <= '0;
      end else begin
         state   <= next_state;
         seq_cnt <= next_seq_cnt;
      end
   end

   // Registered gating outputs
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         CORE_CLK_EN_OUT        <= 1'b1;
         SYS_CLK_EN_OUT         <= 1'b1;
         PLL_EN_OUT             <= 1'b1;
         PLL_BYPASS_OUT         <= 1'b0;
         DMA_L1_EN_OUT          <= 1'b1;
         ASYNC_BLOCK_OUT        <= 1'b0;
         CORE_POWER_OUT         <= 1'b1;
         REG_WAKE_A_OUT         <= 1'b1;
         REG_WAKE_B_OUT         <= 1'b1;
         PIN_DRIVE_EN_N_OUT     <= 1'b0;
         SDRAM_SELF_REFRESH_OUT <= 1'b0;
         WAKE_RESET_OUT         <= 1'b0;
      end else begin
         CORE_CLK_EN_OUT        <= state == PM_FULL_ON || state == PM_ACTIVE;
         SYS_CLK_EN_OUT         <= state == PM_FULL_ON || state == PM_ACTIVE
                                || state == PM_SLEEP;
         PLL_EN_OUT             <= state == PM_FULL_ON || state == PM_SLEEP
                                || (state == PM_ACTIVE && !pll_control_reg[PLL_OFF_BIT]);
         PLL_BYPASS_OUT         <= state == PM_ACTIVE;
         DMA_L1_EN_OUT          <= state == PM_FULL_ON || state == PM_ACTIVE;
         ASYNC_BLOCK_OUT        <= state == PM_DEEP_SLEEP || state == PM_HIBERNATE;
         CORE_POWER_OUT         <= state != PM_HIBERNATE;
         REG_WAKE_A_OUT         <= state != PM_HIBERNATE;
         REG_WAKE_B_OUT         <= state != PM_HIBERNATE;
         PIN_DRIVE_EN_N_OUT     <= state == PM_HIBERNATE;
         SDRAM_SELF_REFRESH_OUT <= reg_ctl[SDRAM_HOLD_BIT]
                                && (state == PM_HIBERNATE || state == PM_RESET_SEQ);
         WAKE_RESET_OUT         <= state == PM_RESET_SEQ;
      end
   end

   // Checks
   a_reset_full_on: assert property (@(posedge CLOCK_IN)
      $fell(SYS_RST_IN) |-> state == PM_FULL_ON && CORE_CLK_EN_OUT)
      else $error("not full-on after reset");
   a_full_on_pll: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_FULL_ON |=> PLL_EN_OUT && !PLL_BYPASS_OUT && CORE_CLK_EN_OUT)
      else $error("full-on clocking wrong");
   a_active_bypass: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_ACTIVE && !pll_control_reg[PLL_OFF_BIT] |=> PLL_EN_OUT && PLL_BYPASS_OUT
         && CORE_CLK_EN_OUT && SYS_CLK_EN_OUT)
      else $error("active clocking wrong");
   a_active_dma: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_ACTIVE |=> DMA_L1_EN_OUT)
      else $error("DMA blocked in active");
   a_sleep_clocks: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_SLEEP |=> !CORE_CLK_EN_OUT && SYS_CLK_EN_OUT && PLL_EN_OUT)
      else $error("sleep clocking wrong");
   a_sleep_dma: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_SLEEP |=> !DMA_L1_EN_OUT)
      else $error("DMA allowed in sleep");
   a_sleep_wake: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_SLEEP && sleep_wake |=>
         state == ($past(pll_control_reg[PLL_BYPASS_BIT]) ? PM_ACTIVE : PM_FULL_ON))
      else $error("sleep wake target wrong");
   a_deep_exit: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_DEEP_SLEEP |=> state == ($past(rtc_s) ? PM_ACTIVE : PM_DEEP_SLEEP))
      else $error("deep sleep exit wrong");
   a_deep_clocks: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_DEEP_SLEEP |=> !SYS_CLK_EN_OUT && !CORE_CLK_EN_OUT && ASYNC_BLOCK_OUT)
      else $error("deep sleep clocks running");
   a_hib_entry: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      hib_req && (state == PM_FULL_ON || state == PM_ACTIVE) |=> state == PM_HIBERNATE
         ##1 !REG_WAKE_A_OUT && !REG_WAKE_B_OUT && !CORE_POWER_OUT && PIN_DRIVE_EN_N_OUT)
      else $error("hibernate entry wrong");
   a_reset_seq_len: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      $rose(state == PM_RESET_SEQ) |-> ##125 state == PM_FULL_ON)
      else $error("reset sequence length wrong");
   a_regctl_keep: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_HIBERNATE && !wr_fire |=> $stable(reg_ctl))
      else $error("regulator register lost");
   a_sdram_hold: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN)
      state == PM_HIBERNATE && reg_ctl[SDRAM_HOLD_BIT] |=> SDRAM_SELF_REFRESH_OUT)
      else $error("SDRAM hold missing");
endmodule : pms_sequencer

// >>> logic/pms_sync2.sv
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Synchronous active-high reset
// Notes:   First stage feeds only the second stage
module pms_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta  <= '0;
         q_out <= '0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule : pms_sync2

// >>> verification/pms_partner.sv
// Purpose: Regulator and wake source model
// Assumes: Bench calls fire to raise an event
// Notes:   Wake pin idles high through its pull-up
module pms_partner (
   input  wire logic       clk_in,
   input  wire logic       wake_a_in,
   input  wire logic       wake_b_in,
   output logic            reg_on_out,
   output logic [7:0]      src_out,
   output logic            rtc_out,
   output logic            phy_n_out,
   output logic            usb_out,
   output logic            eth_out
);
   timeunit 1ns;
   timeprecision 1ps;
   assign reg_on_out = wake_a_in | wake_b_in;
   initial begin
      src_out = 8'h00;
      rtc_out = 1'b0;
      phy_n_out = 1'b1;
      usb_out = 1'b0;
      eth_out = 1'b0;
   end
   task automatic fire(input int k, input logic [7:0] m);
      @(posedge clk_in);
      src_out <= m;
      rtc_out <= (k == 1);
      phy_n_out <= (k != 2);
      usb_out <= (k == 3);
      eth_out <= (k == 4);
      repeat (4) @(posedge clk_in);
      src_out <= 8'h00;
      rtc_out <= 1'b0;
      phy_n_out <= 1'b1;
      usb_out <= 1'b0;
      eth_out <= 1'b0;
   endtask : fire
endmodule : pms_partner

// >>> verification/pms_sequencer_tb.sv
// Purpose: Self-checking bench of the mode sequencer
// Assumes: AXI4-Lite master tasks, 125 MHz clock
// Notes:   Output table per state as reference
module pms_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pms_pkg::*;
   logic clk, rst, awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd, rtc, phy_n, ron, usb, eth;
   logic [7:0] aw, ar, src, m;
   logic [31:0] wd, rdat, q, v;
   logic [1:0] bresp, rresp, r;
   logic [11:0] o;
   int n_tests = 0, miscompares = 0, ms, moff, mhold, nrst, i, k;
   int unsigned seed = 59;
   pms_sequencer #(.WAKE_W(8)) pms_sequencer_inst (
      .CLOCK_IN(clk), .SYS_RST_IN(rst), .S_AXI_AWADDR_IN(aw), .S_AXI_AWVALID_IN(awv),
      .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
      .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(brd), .S_AXI_ARADDR_IN(ar),
      .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrd),
      .WAKE_SRC_IN(src), .RTC_EVENT_IN(rtc), .USB_WAKE_IN(usb), .ETH_WAKE_IN(eth),
      .PHY_WAKE_PIN_N_IN(phy_n), .CORE_CLK_EN_OUT(o[11]), .SYS_CLK_EN_OUT(o[10]),
      .PLL_EN_OUT(o[9]), .PLL_BYPASS_OUT(o[8]), .DMA_L1_EN_OUT(o[7]),
      .ASYNC_BLOCK_OUT(o[6]), .CORE_POWER_OUT(o[5]), .REG_WAKE_A_OUT(o[4]),
      .REG_WAKE_B_OUT(o[3]), .PIN_DRIVE_EN_N_OUT(o[2]), .SDRAM_SELF_REFRESH_OUT(o[1]),
      .WAKE_RESET_OUT(o[0]));
   pms_partner pms_partner_inst (.clk_in(clk), .wake_a_in(o[4]), .wake_b_in(o[3]),
      .reg_on_out(ron), .src_out(src), .rtc_out(rtc), .phy_n_out(phy_n),
      .usb_out(usb), .eth_out(eth));
   always #4 clk = ~clk;
   always @(posedge clk) if (o[0]) nrst <= nrst + 1;
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [11:0] exp_o();
      case (ms)
         0: return 12'hEB8;
         1: return (moff != 0) ? 12'hDB8 : 12'hFB8;
         2: return 12'h638;
         3: return 12'h078;
         default: return (mhold != 0) ? 12'h046 : 12'h044;
      endcase
   endfunction : exp_o
   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      logic [3:0] t;
      @(posedge clk);
      if (w) begin
         aw <= a;
         wd <= d;
         awv <= 1'b1;
         wv <= 1'b1;
         brd <= 1'b1;
      end else begin
         ar <= a;
         arv <= 1'b1;
         rrd <= 1'b1;
      end
      repeat (50) begin
         @(negedge clk);
         t = {awr, wrd, arr, w ? bv : rv};
         q = rdat;
         r = w ? bresp : rresp;
         @(posedge clk);
         if (t[3]) awv <= 1'b0;
         if (t[2]) wv <= 1'b0;
         if (t[1]) arv <= 1'b0;
         if (t[0]) begin
            brd <= 1'b0;
            rrd <= 1'b0;
            return;
         end
      end
      miscompares++;
      complete_run();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      cmp(32'(r), 32'(RESP_OKAY));
      repeat (8) @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      cmp(q, e);
   endtask : rd
   task automatic chk;
      repeat (8) @(negedge clk);
      cmp(32'(o), 32'(exp_o()));
   endtask : chk
   initial begin
      {clk, awv, wv, brd, arv, rrd, aw, ar, wd} = '0;
      {ms, moff, mhold, nrst} = '0;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      chk();
      rd(REG_CTL_OFS, 32'h0F03);
      bus(1'b0, 8'h14, 32'h0);
      cmp(32'(r), 32'(RESP_SLVERR));
      wr(PLL_CONTROL_REG_OFS, 32'h1);
      wr(MODE_CMD_OFS, 32'(CMD_ACTIVE));
      ms = 1;
      chk();
      wr(PLL_CONTROL_REG_OFS, 32'h3);
      moff = 1;
      chk();
      wr(PLL_CONTROL_REG_OFS, 32'h1);
      moff = 0;
      m = 8'(1 << (xs() % 8));
      wr(WAKE_EN_OFS, 32'(m));
      for (i = 0; i < 2; i++) begin
         wr(PLL_CONTROL_REG_OFS, 32'(1 - i));
         wr(MODE_CMD_OFS, 32'(CMD_SLEEP));
         ms = 2;
         chk();
         pms_partner_inst.fire(0, ~m);
         chk();
         pms_partner_inst.fire(0, m);
         ms = 1 - i;
         chk();
      end
      wr(MODE_CMD_OFS, 32'(CMD_DEEP_SLEEP));
      ms = 3;
      chk();
      pms_partner_inst.fire(1, 8'h00);
      ms = 1;
      chk();
      for (k = 2; k < 5; k++) begin
         v = 32'h1000 | (32'h1 << ((k == 2) ? 11 : k + 6));
         wr(PLL_CONTROL_REG_OFS, 32'h1);
         wr(REG_CTL_OFS, v);
         {ms, mhold} = {32'd4, 32'd1};
         chk();
         cmp(32'(ron), 32'h0);
         pms_partner_inst.fire(1, 8'h00);
         chk();
         nrst = 0;
         pms_partner_inst.fire(k, 8'h00);
         for (i = 0; i < 400 && (o[0] || nrst == 0); i++) @(negedge clk);
         if (i == 400) begin
            miscompares++;
            complete_run();
         end
         cmp(32'(nrst), 32'(RST_SEQ_CYC));
         {ms, mhold} = '0;
         chk();
         cmp(32'(ron), 32'h1);
         rd(REG_CTL_OFS, v);
         rd(PLL_CONTROL_REG_OFS, 32'h0);
         rd(WAKE_EN_OFS, 32'h0);
      end
      wr(MODE_CMD_OFS, 32'(CMD_DEEP_SLEEP));
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk();
      complete_run();
   end
endmodule : pms_sequencer_tb
